// File: rtl/pmcs_pkg.sv
// Package with constants and types for the power-mode clock switcher.
`default_nettype none
package pmcs_pkg;
  // Oscillator control register bit positions.
  localparam int OSC_SCS_LO_BIT   = 0;
  localparam int OSC_SCS_HI_BIT   = 1;
  localparam int OSC_INTERNAL_OSC_STABLE_FLAG_BIT     = 2;
  localparam int OSC_PRIMARY_CLOCK_RUNNING_FLAG_BIT     = 3;
  localparam int OSC_IDLE_BIT     = 7;
  // Secondary timer control register bit position.
  localparam int T1C_RUN_BIT      = 6;
  // Switch timing, counted in cycles of the outgoing and incoming clock.
  localparam int SW_OLD_CYCLES    = 2;
  localparam int SW_NEW_CYCLES    = 4;
  // Fast internal oscillator nominal output.
  localparam int FAST_OSC_HZ      = 8000000;
  // Timing constants in ns and cycles at 100 MHz.
  localparam int CLK_PERIOD_NS    = 10;
  localparam int READY_DELAY_NS   = 200;
  localparam int READY_DELAY_CYC  = (READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_TIME_NS   = 1000;
  localparam int SETTLE_CYC       = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Reset values.
  localparam logic [1:0] SCS_RESET = 2'h0;

  typedef enum logic [1:0] {
    PMCS_SRC_PRI,
    PMCS_SRC_SEC,
    PMCS_SRC_INT
  } pmcs_src_t;

  typedef struct packed {
    logic primary_clock_running_flag;
    logic internal_osc_stable_flag;
    logic secondary_clock_active_flag;
  } pmcs_flags_t;

  typedef struct packed {
    logic watchdog_timeout;
    logic irq_wake;
    logic dev_reset;
  } pmcs_wake_t;
endpackage : pmcs_pkg
`default_nettype wire

// File: rtl/pmcs_sync.sv
// Two-flop synchroniser for asynchronous level inputs.
`default_nettype none
module pmcs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : pmcs_sync
`default_nettype wire

// File: rtl/pmcs_ctrl.sv
// Power-mode and clock-source controller: run, idle and sleep sequencing.
`default_nettype none
// How it works
// - Switch costs two old plus four new cycles.
// - Keep primary, internal and secondary status flags.
// - Internal flag only when fast oscillator stable.
// - No flags means slow or unsettled internal.
// - Internal primary may show both; internal run clears primary.
// - Power-down samples idle bit at that moment.
// - Reset without dual speed starts primary run, primary flag set.
// - Select 01 moves to secondary, flags updated.
// - Secondary disabled refuses; not running holds clocks.
// - Back to primary waits ready, then swaps flags.
// - Upper select bit enters internal run.
// - Frequency bits and low-frequency select clear keep fast oscillator off.
// - Enabling fast oscillator sets flag after settling.
// - Internal to primary waits ready, swaps flags.
// - Sleep shuts oscillator, clears all flags.
// - Sleep performs no switch; keepers stay on.
// - Sleep wake waits source or runs internal.
// - Idle gates CPU only, flags unchanged.
// - Idle exits by wake events after ready delay.
// - Watchdog in low power wakes into selection.
// - Idle select bit is control bit seven.
// - Select field bits one to zero.
// - Writing select starts switch unless secondary is disabled.
module pmcs_ctrl
  import pmcs_pkg::*;
#(
  parameter int READY_CYC  = READY_DELAY_CYC,
  parameter int SETTLE_CYCS = SETTLE_CYC
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               sys_rst_i,
  // Control bits written by the core
  input  wire logic               idle_on_powerdown_select_i,
  input  wire logic [1:0]         clock_source_select_i,
  input  wire logic [2:0]         internal_freq_select_i,
  input  wire logic               low_freq_source_select_i,
  input  wire logic               secondary_osc_enable_i,
  input  wire logic               powerdown_instr_i,
  // Configuration straps
  input  wire logic               primary_is_internal_i,
  input  wire logic               dual_speed_startup_i,
  input  wire logic               clock_monitor_enable_i,
  input  wire logic               watchdog_timer_enable_i,
  // Oscillator readiness from the analog side, asynchronous
  input  wire logic               primary_ready_i,
  input  wire logic               secondary_running_i,
  // Wake sources
  input  wire logic [7:0]         irq_flag_i,
  input  wire logic [7:0]         irq_enable_i,
  input  wire logic               watchdog_timeout_i,
  // Status flags and their register images
  output pmcs_pkg::pmcs_flags_t   flags_o,
  output logic [7:0]              oscillator_control_register_o,
  output logic [7:0]              secondary_timer_control_register_o,
  // Clock steering
  output pmcs_pkg::pmcs_src_t     clk_src_o,
  output logic                    cpu_clk_en_o,
  output logic                    periph_clk_en_o,
  output logic                    primary_osc_en_o,
  output logic                    fast_internal_oscillator_en_o,
  output logic                    slow_internal_oscillator_en_o,
  output logic                    secondary_osc_run_o,
  output logic                    sleeping_o,
  output logic                    idling_o
);
  import pmcs_pkg::*;

  // Counters are sixteen bits wide, which bounds both delays.
  if (READY_CYC < 1 || READY_CYC > 65535 ||
      SETTLE_CYCS < 1 || SETTLE_CYCS > 65535) begin : g_bad_delay
    $error("pmcs_ctrl: delay parameters out of range");
  end

  typedef enum logic [2:0] {
    ST_RUN,
    ST_SW_OLD,
    ST_SW_NEW,
    ST_WAIT_PRI,
    ST_IDLE,
    ST_SLEEP,
    ST_WAKE
  } pmcs_state_t;

  function automatic pmcs_src_t decode_src(input logic [1:0] sel);
    if (sel[1])
      decode_src = PMCS_SRC_INT;
    else if (sel[0])
      decode_src = PMCS_SRC_SEC;
    else
      decode_src = PMCS_SRC_PRI;
  endfunction : decode_src

  // Readiness lines come from free-running oscillators, so they are synchronised.
  logic pri_rdy_s;
  logic secondary_run_mode_s;
  pmcs_sync #(.W(2)) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       ({primary_ready_i, secondary_running_i}),
    .q_o       ({pri_rdy_s, secondary_run_mode_s})
  );

  pmcs_state_t state_q, state_d;
  pmcs_src_t   src_q, src_d, target_q, target_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] settle_q, settle_d;
  logic        primary_clock_running_flag_q, primary_clock_running_flag_d, internal_osc_stable_flag_q, internal_osc_stable_flag_d, secondary_clock_active_flag_q, secondary_clock_active_flag_d;
  logic        fast_on_q;
  logic        boot_q, boot_d;

  wire pmcs_src_t sel_src   = decode_src(clock_source_select_i);
  wire logic fast_req       = (internal_freq_select_i != 3'h0) || low_freq_source_select_i;
  wire logic wake_evt       = (|(irq_flag_i & irq_enable_i)) || watchdog_timeout_i;
  wire logic sel_ok         = (sel_src != PMCS_SRC_SEC) || secondary_osc_enable_i;
  wire logic src_ready      = (target_q == PMCS_SRC_PRI) ? pri_rdy_s :
                              (target_q == PMCS_SRC_SEC) ? secondary_run_mode_s : 1'b1;
  wire logic fast_stable    = fast_on_q && (settle_q == 16'h0);
  wire logic internal_fill  = dual_speed_startup_i || clock_monitor_enable_i;

  // The settle counter restarts whenever the fast oscillator is turned on.
  always_comb begin
    settle_d = settle_q;
    if (!fast_req || state_q == ST_SLEEP)
      settle_d = 16'(SETTLE_CYCS);
    else if (settle_q != 16'h0)
      settle_d = settle_q - 16'h1;
  end

  always_comb begin
    state_d  = state_q;
    src_d    = src_q;
    target_d = target_q;
    cnt_d    = (cnt_q != 16'h0) ? cnt_q - 16'h1 : cnt_q;
    primary_clock_running_flag_d   = primary_clock_running_flag_q;
    secondary_clock_active_flag_d  = secondary_clock_active_flag_q;
    boot_d   = boot_q;
    case (state_q)
      ST_RUN: begin
        if (powerdown_instr_i) begin
          if (idle_on_powerdown_select_i)
            state_d = ST_IDLE;
          else begin
            state_d = ST_SLEEP;
            primary_clock_running_flag_d  = 1'b0;
            secondary_clock_active_flag_d = 1'b0;
            boot_d  = 1'b0;
          end
        end else if (sel_src != src_q && sel_ok) begin
          target_d = sel_src;
          if (sel_src == PMCS_SRC_PRI)
            state_d = ST_WAIT_PRI;
          else begin
            state_d = ST_SW_OLD;
            cnt_d   = 16'(SW_OLD_CYCLES - 1);
          end
        end else if (boot_q && pri_rdy_s) begin
          boot_d = 1'b0;
          src_d  = PMCS_SRC_PRI;
          primary_clock_running_flag_d = 1'b1;
        end
      end
      ST_WAIT_PRI: begin
        if (sel_src != PMCS_SRC_PRI) begin
          state_d  = ST_RUN;
          target_d = src_q;
        end else if (pri_rdy_s) begin
          state_d = ST_SW_OLD;
          cnt_d   = 16'(SW_OLD_CYCLES - 1);
        end
      end
      ST_SW_OLD: begin
        if (cnt_q == 16'h0 && src_ready) begin
          state_d = ST_SW_NEW;
          cnt_d   = 16'(SW_NEW_CYCLES - 1);
        end
      end
      ST_SW_NEW: begin
        if (cnt_q == 16'h0) begin
          state_d = ST_RUN;
          src_d   = target_q;
          boot_d  = 1'b0;
          primary_clock_running_flag_d  = (target_q == PMCS_SRC_PRI);
          secondary_clock_active_flag_d = (target_q == PMCS_SRC_SEC);
        end
      end
      ST_IDLE: begin
        if (wake_evt) begin
          state_d = ST_WAKE;
          cnt_d   = 16'(READY_CYC - 1);
          // Wake readiness is judged on the source in use, not on a stale target.
          target_d = src_q;
        end
      end
      ST_SLEEP: begin
        if (wake_evt) begin
          state_d  = ST_WAKE;
          cnt_d    = 16'(READY_CYC - 1);
          target_d = src_q;
          src_d    = (src_q == PMCS_SRC_PRI && internal_fill) ? PMCS_SRC_INT : src_q;
          boot_d   = (src_q == PMCS_SRC_PRI && internal_fill);
          secondary_clock_active_flag_d  = (src_q == PMCS_SRC_SEC);
        end
      end
      ST_WAKE: begin
        if (cnt_q == 16'h0 && (boot_q || src_ready || target_q == src_q && src_q != PMCS_SRC_PRI
                                || target_q == PMCS_SRC_PRI && pri_rdy_s)) begin
          state_d = ST_RUN;
          primary_clock_running_flag_d  = (src_q == PMCS_SRC_PRI) && pri_rdy_s;
          secondary_clock_active_flag_d = (src_q == PMCS_SRC_SEC);
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  // Internal-stable flag follows the fast oscillator, cleared when leaving it.
  always_comb begin
    internal_osc_stable_flag_d = 1'b0;
    if (state_d == ST_SLEEP || state_q == ST_SLEEP)
      internal_osc_stable_flag_d = 1'b0;
    else if (src_d == PMCS_SRC_INT || (src_d == PMCS_SRC_PRI && primary_is_internal_i))
      internal_osc_stable_flag_d = fast_stable;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q   <= ST_RUN;
      src_q     <= PMCS_SRC_PRI;
      target_q  <= PMCS_SRC_PRI;
      cnt_q     <= 16'h0;
      settle_q  <= 16'h0;
      primary_clock_running_flag_q    <= 1'b0;
      internal_osc_stable_flag_q    <= 1'b0;
      secondary_clock_active_flag_q   <= 1'b0;
      fast_on_q <= 1'b0;
      boot_q    <= 1'b1;
    end else begin
      state_q   <= state_d;
      src_q     <= src_d;
      target_q  <= target_d;
      cnt_q     <= cnt_d;
      settle_q  <= settle_d;
      primary_clock_running_flag_q    <= primary_clock_running_flag_d;
      internal_osc_stable_flag_q    <= internal_osc_stable_flag_d;
      secondary_clock_active_flag_q   <= secondary_clock_active_flag_d;
      fast_on_q <= fast_req && state_d != ST_SLEEP;
      boot_q    <= boot_d;
    end
  end

  // Straps decide the first clock: dual speed starts internally, else primary.
  always_comb begin
    clk_src_o = src_q;
    if (boot_q && dual_speed_startup_i)
      clk_src_o = PMCS_SRC_INT;
  end

  // The boot term only stands for the primary; a wake onto the internal block must not show it.
  assign flags_o.primary_clock_running_flag  = primary_clock_running_flag_q ||
                                               (boot_q && !dual_speed_startup_i &&
                                                src_q == PMCS_SRC_PRI);
  assign flags_o.internal_osc_stable_flag    = internal_osc_stable_flag_q;
  assign flags_o.secondary_clock_active_flag = secondary_clock_active_flag_q;

  always_comb begin
    oscillator_control_register_o                 = 8'h00;
    oscillator_control_register_o[OSC_IDLE_BIT]   = idle_on_powerdown_select_i;
    oscillator_control_register_o[OSC_PRIMARY_CLOCK_RUNNING_FLAG_BIT]   = flags_o.primary_clock_running_flag;
    oscillator_control_register_o[OSC_INTERNAL_OSC_STABLE_FLAG_BIT]   = internal_osc_stable_flag_q;
    oscillator_control_register_o[OSC_SCS_HI_BIT] = clock_source_select_i[1];
    oscillator_control_register_o[OSC_SCS_LO_BIT] = clock_source_select_i[0];
    secondary_timer_control_register_o              = 8'h00;
    secondary_timer_control_register_o[T1C_RUN_BIT] = secondary_clock_active_flag_q;
  end

  wire logic in_sleep = (state_q == ST_SLEEP);
  // An enabled but silent secondary oscillator holds every clock off until it starts.
  wire logic sec_stall = (state_q == ST_SW_OLD) && (target_q == PMCS_SRC_SEC) &&
                         !secondary_run_mode_s;
  wire logic clocked  = !in_sleep && !sec_stall && !(state_q == ST_WAKE && !boot_q && !src_ready);
  assign sleeping_o      = in_sleep;
  assign idling_o        = (state_q == ST_IDLE);
  assign cpu_clk_en_o    = clocked && state_q != ST_IDLE && state_q != ST_WAKE;
  assign periph_clk_en_o = clocked;
  // Primary keeps running during a return to it and in primary modes only.
  assign primary_osc_en_o = !in_sleep &&
                            (src_q == PMCS_SRC_PRI || state_q == ST_WAIT_PRI ||
                             target_q == PMCS_SRC_PRI);
  assign fast_internal_oscillator_en_o = fast_on_q;
  assign slow_internal_oscillator_en_o = watchdog_timer_enable_i || clock_monitor_enable_i ||
                                         (!in_sleep && src_q == PMCS_SRC_INT && !fast_req);
  assign secondary_osc_run_o = secondary_osc_enable_i;
endmodule : pmcs_ctrl
`default_nettype wire

// File: bench/pmcs_ctrl_checker.sv
// Concurrent assertions for the power-mode clock switcher ports.
`default_nettype none
module pmcs_ctrl_checker
  import pmcs_pkg::*;
(
  // Clock, reset and control levels
  input wire logic                  clk_i,
  input wire logic                  sys_rst_i,
  input wire logic [2:0]            internal_freq_select_i,
  input wire logic                  low_freq_source_select_i,
  input wire logic                  secondary_osc_enable_i,
  // Observed outputs
  input wire pmcs_pkg::pmcs_flags_t flags_o,
  input wire logic [7:0]            oscillator_control_register_o,
  input wire logic [7:0]            secondary_timer_control_register_o,
  input wire pmcs_pkg::pmcs_src_t   clk_src_o,
  input wire logic                  cpu_clk_en_o,
  input wire logic                  periph_clk_en_o,
  input wire logic                  fast_internal_oscillator_en_o,
  input wire logic                  sleeping_o,
  input wire logic                  idling_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  flag_image_a: assert property (
    {oscillator_control_register_o[3:2], secondary_timer_control_register_o[6]} == flags_o)
    else $error("status flag images differ from flags");
  sleep_clear_a: assert property ($rose(sleeping_o) |-> flags_o == 3'h0)
    else $error("sleep entry left a status flag set");
  idle_gate_a: assert property ($rose(idling_o) |-> !cpu_clk_en_o && periph_clk_en_o)
    else $error("idle entry did not gate only the cpu clock");
  idle_flags_a: assert property ($rose(idling_o) |-> $stable(flags_o))
    else $error("idle entry changed status flags");
  sec_refuse_a: assert property (
    !secondary_osc_enable_i && clk_src_o != PMCS_SRC_SEC |=> clk_src_o != PMCS_SRC_SEC)
    else $error("secondary run entered with oscillator disabled");
  sec_flags_a: assert property (
    clk_src_o == PMCS_SRC_SEC && !sleeping_o |-> flags_o == 3'h1)
    else $error("secondary source without matching flags");
  // A shorter switch would hand over before the incoming clock is safely captured.
  switch_time_a: assert property (
    $changed(clk_src_o) && clk_src_o != PMCS_SRC_PRI |-> $past(clk_src_o, 6) == $past(clk_src_o))
    else $error("clock switch completed too early");
  sec_latency_a: assert property (
    $changed(clk_src_o) && clk_src_o == PMCS_SRC_SEC
    |-> $past(oscillator_control_register_o[1:0], 7) == 2'h1)
    else $error("secondary switch shorter than the transition time");
  int_primary_a: assert property (
    clk_src_o == PMCS_SRC_INT && !sleeping_o |-> !flags_o.primary_clock_running_flag)
    else $error("internal run with primary flag set");
  fast_off_a: assert property (
    (internal_freq_select_i == 3'h0 && !low_freq_source_select_i)[*3]
    |-> !fast_internal_oscillator_en_o && !flags_o.internal_osc_stable_flag)
    else $error("fast internal oscillator on with all selects clear");
endmodule : pmcs_ctrl_checker
bind pmcs_ctrl pmcs_ctrl_checker u_pmcs_ctrl_checker (.*);
`default_nettype wire

// File: bench/pmcs_core_model.sv
// Processor core model: writes control bits and issues power-down pulses.
`default_nettype none
module pmcs_core_model (
  // Clock and configuration
  input  wire logic       clk_i,
  input  wire logic       primary_is_internal_i,
  // Requests from the bench
  input  wire logic [1:0] sel_req_i,
  input  wire logic       idle_req_i,
  input  wire logic       pd_req_i,
  // Control bits seen by the controller
  output var  logic [1:0] clock_source_select_o = 2'h0,
  output var  logic       idle_on_powerdown_select_o = 1'h0,
  output var  logic       powerdown_instr_o = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pd_seen_q = 1'h0;
  // Writes retire mid-cycle so the controller sees settled levels at its edge.
  always @(negedge clk_i) begin
    clock_source_select_o <= (primary_is_internal_i && sel_req_i[1]) ? 2'h0 : sel_req_i;
    idle_on_powerdown_select_o <= idle_req_i;
    powerdown_instr_o <= pd_req_i && !pd_seen_q;
    pd_seen_q <= pd_req_i;
  end
endmodule : pmcs_core_model
`default_nettype wire

// File: bench/pmcs_ctrl_tb.sv
// Self-checking testbench for the power-mode clock switcher.
`default_nettype none
module pmcs_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pmcs_pkg::*;
  localparam int RC = 2;
  logic        clk_i = 1'h0, sys_rst_i = 1'h1, idle_req = 1'h0, pd_req = 1'h0;
  logic        low_freq_source_select_i = 1'h0, secondary_osc_enable_i = 1'h0;
  logic        primary_ready_i = 1'h1, watchdog_timeout_i = 1'h0, secondary_running_i = 1'h1;
  logic        primary_is_internal_i = 1'h0, dual_speed_startup_i = 1'h0;
  logic        clock_monitor_enable_i = 1'h0, watchdog_timer_enable_i = 1'h1;
  logic        idle_on_powerdown_select_i, powerdown_instr_i;
  logic [1:0]  clock_source_select_i, sel_req = 2'h0;
  logic [2:0]  internal_freq_select_i = 3'h0;
  logic [7:0]  irq_flag_i = 8'h00, irq_enable_i = 8'h00, r8;
  logic [7:0]  oscillator_control_register_o, secondary_timer_control_register_o;
  logic        cpu_clk_en_o, periph_clk_en_o, primary_osc_en_o, fast_internal_oscillator_en_o;
  logic        slow_internal_oscillator_en_o, secondary_osc_run_o, sleeping_o, idling_o;
  logic [31:0] rs = 32'h0000_0053;
  int          n_fail = 0, n_compared = 0, n;
  pmcs_flags_t flags_o;
  pmcs_src_t   clk_src_o;

  initial begin
    forever #5 clk_i = ~clk_i;
  end
  pmcs_core_model u_pmcs_core_model (.clk_i(clk_i), .primary_is_internal_i(primary_is_internal_i),
    .sel_req_i(sel_req), .idle_req_i(idle_req), .pd_req_i(pd_req),
    .clock_source_select_o(clock_source_select_i),
    .idle_on_powerdown_select_o(idle_on_powerdown_select_i), .powerdown_instr_o(powerdown_instr_i));
  pmcs_ctrl #(.READY_CYC(RC), .SETTLE_CYCS(3)) u_pmcs_ctrl (.*);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask : cyc
  function automatic logic [31:0] next_rand();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : next_rand
  function automatic logic [2:0] run_flags(input pmcs_src_t s, input logic fast_on);
    case (s)
      PMCS_SRC_PRI: return 3'h4;
      PMCS_SRC_SEC: return 3'h1;
      default:      return {1'h0, fast_on, 1'h0};
    endcase
  endfunction : run_flags
  // Bounded waits; n keeps the cycles spent so latencies can be judged.
  task automatic wait_src(input pmcs_src_t s);
    n = 0;
    while (clk_src_o !== s && n < 200) begin
      @(negedge clk_i);
      n++;
    end
  endtask : wait_src
  task automatic wait_cpu();
    n = 0;
    while (cpu_clk_en_o !== 1'h1 && n < 50) begin
      @(negedge clk_i);
      n++;
    end
  endtask : wait_cpu
  task automatic set_sel(input logic [1:0] v, input pmcs_src_t s);
    sel_req <= v;
    cyc(1);
    wait_src(s);
  endtask : set_sel
  task automatic powerdown(input logic idle);
    idle_req <= idle;
    cyc(2);
    pd_req <= 1'h1;
    cyc(3);
    pd_req <= 1'h0;
  endtask : powerdown

  initial begin
    #50us;
    n_fail++;
    final_report();
  end
  initial begin
    cyc(16);
    sys_rst_i <= 1'h0;
    cyc(1);
    check(flags_o, run_flags(PMCS_SRC_PRI, 1'h0));
    check({clk_src_o, oscillator_control_register_o[1:0]}, 4'h0);
    set_sel(2'h1, PMCS_SRC_SEC);
    check(clk_src_o, PMCS_SRC_PRI);
    set_sel(2'h0, PMCS_SRC_PRI);
    secondary_osc_enable_i <= 1'h1;
    set_sel(2'h1, PMCS_SRC_SEC);
    check(n >= SW_OLD_CYCLES + 3 && n <= SW_OLD_CYCLES + SW_NEW_CYCLES + 2, 1'h1);
    check({flags_o, primary_osc_en_o}, {run_flags(PMCS_SRC_SEC, 1'h0), 1'h0});
    primary_ready_i <= 1'h0;
    sel_req <= 2'h0;
    cyc(20);
    check(clk_src_o, PMCS_SRC_SEC);
    primary_ready_i <= 1'h1;
    wait_src(PMCS_SRC_PRI);
    check({flags_o, secondary_osc_run_o}, {run_flags(PMCS_SRC_PRI, 1'h0), 1'h1});
    set_sel(2'h3, PMCS_SRC_INT);
    check(flags_o, run_flags(PMCS_SRC_INT, 1'h0));
    internal_freq_select_i <= 3'(next_rand() % 7 + 1);
    cyc(12);
    check({flags_o, cpu_clk_en_o}, {run_flags(PMCS_SRC_INT, 1'h1), 1'h1});
    internal_freq_select_i <= 3'h0;
    low_freq_source_select_i <= 1'h1;
    cyc(3);
    check(flags_o, run_flags(PMCS_SRC_INT, 1'h1));
    set_sel(2'h0, PMCS_SRC_PRI);
    check({flags_o, slow_internal_oscillator_en_o}, 4'h9);
    low_freq_source_select_i <= 1'h0;
    powerdown(1'h1);
    check({idling_o, cpu_clk_en_o, periph_clk_en_o, flags_o}, 6'h2c);
    r8 = 8'h01 << (next_rand() % 8);
    irq_flag_i <= r8;
    irq_enable_i <= ~r8;
    cyc(10);
    check(idling_o, 1'h1);
    irq_enable_i <= r8;
    wait_cpu();
    check(n >= RC && n <= RC + 3, 1'h1);
    check({clk_src_o, oscillator_control_register_o[7]}, 3'h1);
    primary_is_internal_i <= 1'h1;
    internal_freq_select_i <= 3'h7;
    cyc(8);
    check(flags_o, 3'h6);
    primary_is_internal_i <= 1'h0;
    internal_freq_select_i <= 3'h0;
    irq_flag_i <= 8'h00;
    powerdown(1'h0);
    check({sleeping_o, flags_o}, 4'h8);
    check({slow_internal_oscillator_en_o, secondary_osc_run_o}, 2'h3);
    watchdog_timeout_i <= 1'h1;
    cyc(1);
    watchdog_timeout_i <= 1'h0;
    wait_cpu();
    check({sleeping_o, clk_src_o, flags_o}, 6'h04);
    final_report();
  end
endmodule : pmcs_ctrl_tb
`default_nettype wire
